// ---- design/ctrl_regs_pkg.sv ----
package ctrl_regs_pkg;
	// clock and timing
	localparam int CLK_HZ         = 20_000_000;
	localparam int BLINK_HALF_MS  = 500;
	localparam int BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
	localparam int CYCLE_OFF_MS   = 1000;
	localparam int CYCLE_OFF_CYC  = CYCLE_OFF_MS * (CLK_HZ / 1000);

	// register indexes, byte address is four times the index
	localparam logic [7:0] IDX_BOARD = 8'h00;
	localparam logic [7:0] IDX_REV   = 8'h01;
	localparam logic [7:0] IDX_SUB   = 8'h02;
	localparam logic [7:0] IDX_LAMP  = 8'h08;
	localparam logic [7:0] IDX_PORT  = 8'h09;
	localparam logic [7:0] IDX_OOB   = 8'h0A;
	localparam logic [7:0] IDX_WDOG  = 8'h0C;
	localparam logic [7:0] IDX_RST   = 8'h10;
	localparam logic [7:0] IDX_SLEEP = 8'h11;
	localparam logic [7:0] IDX_FWDIS = 8'h12;
	localparam logic [7:0] IDX_PWR   = 8'h14;
	localparam logic [7:0] IDX_FLASH = 8'h15;
	localparam logic [7:0] IDX_IRQ   = 8'h21;
	localparam logic [7:0] IDX_MASK  = 8'h28;
	localparam logic [7:0] IDX_PGOOD = 8'h30;
	localparam logic [7:0] IDX_RAIL  = 8'h31;
	localparam logic [7:0] IDX_ISOA  = 8'h32;
	localparam logic [7:0] IDX_ISOB  = 8'h33;
	localparam logic [7:0] IDX_THERM = 8'h34;
	localparam logic [7:0] IDX_MISCA = 8'h35;
	localparam logic [7:0] IDX_MISCB = 8'h36;
	localparam logic [7:0] IDX_LOAD  = 8'h37;
	localparam logic [7:0] IDX_UART  = 8'h38;
	localparam logic [7:0] IDX_STATB = 8'h39;
	localparam logic [7:0] IDX_STATC = 8'h3A;
	localparam logic [7:0] IDX_CLR   = 8'h3B;

	// field positions
	localparam int LAMP_HW_BIT  = 4;
	localparam int LAMP_BLK_BIT = 3;
	localparam int CYC_BIT      = 2;
	localparam int CLR_DBG_BIT  = 1;

	// reset values and writable masks
	localparam logic [4:0] RST_LAMP  = 5'h17;
	localparam logic [5:0] RST_RSTC  = 6'h3F;
	localparam logic [6:0] RST_MASK  = 7'h22;
	localparam logic [7:0] RST_RAIL  = 8'hDF;
	localparam logic [7:0] MSK_RAIL  = 8'hDF;
	localparam logic [7:0] MSK_ISOA  = 8'hDF;
	localparam logic [5:0] RST_ISOB  = 6'h3C;
	localparam logic [5:0] MSK_ISOB  = 6'h3D;
	localparam logic [7:1] RST_MISCA = 7'h07;

	// identity values, arbitrary
	localparam logic       ID_RELEASED = 1'b0;
	localparam logic [5:0] ID_LOGIC_REV = 6'h01;
	localparam logic [7:0] ID_SUB_REV  = 8'h00;

	typedef enum logic {CYC_IDLE, CYC_OFF} cycle_state_t;
endpackage

// ---- design/module_ctrl_reg_bank.sv ----
// The Avalon-MM slave port was decided locally.
module module_ctrl_reg_bank
	import ctrl_regs_pkg::*;
#(
	parameter int BLINK_CYC = BLINK_HALF_CYC,
	parameter int CYCLE_CYC = CYCLE_OFF_CYC
) (
	// clock, reset, enable
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	// avalon-mm slave
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// status inputs
	input  wire logic [3:0]  board_rev,
	input  wire logic [2:0]  hw_lamp_n,
	input  wire logic [2:0]  mgmt_lamp_input,
	input  wire logic        watchdog_state,
	input  wire logic [3:0]  sleep_state,
	input  wire logic [5:0]  irq_src_n,
	input  wire logic        hot_swap_good,
	input  wire logic [4:0]  rail_good,
	input  wire logic        thermal_trip_n,
	input  wire logic [5:3]  misc_status_in,
	input  wire logic [2:0]  redriver_load_done_n,
	input  wire logic        console_route_a,
	input  wire logic        console_route_b,
	input  wire logic        bandwidth_full,
	input  wire logic [6:0]  misc4_in,
	input  wire logic        front_power_button_n,
	input  wire logic        debug_button_n,
	// lamp outputs
	output logic             lamp_red_n,
	output logic             lamp_green_n,
	output logic             lamp_blue_n,
	output logic             optical_lamp_green,
	output logic             optical_lamp_orange,
	output logic             copper_lamp_green,
	output logic             copper_lamp_orange,
	// module control outputs
	output logic             module_power_button,
	output logic             module_power_good_drive,
	output logic             slot_reset_n,
	output logic             bus_switch_reset_n,
	output logic             phy_reset_n,
	output logic             module_reset_n,
	output logic             module_power_en,
	output logic [1:0]       firmware_disable_n,
	output logic             flash_to_mgmt,
	output logic             flash_oe_n,
	output logic [7:0]       rail_enable,
	output logic [7:0]       isolation_a_n,
	output logic [5:0]       isolation_b_n,
	output logic [7:1]       misc_control,
	output logic [1:0]       misc_control_b,
	output logic             irq_out
);
	logic             wait_r;
	logic [31:0]      rdata_r;
	logic [4:0]       lamp_ctl_r;
	logic             port_src_r;
	logic [3:0]       port_lamp_r;
	logic [5:0]       rst_ctl_r;
	logic [1:0]       fw_dis_r;
	logic             pwr_en_r;
	logic             pwr_cyc_n_r;
	logic [1:0]       flash_r;
	logic [6:0]       mask_r;
	logic [7:0]       rail_r;
	logic [7:0]       iso_a_r;
	logic [5:0]       iso_b_r;
	logic [7:1]       misc_a_r;
	logic [1:0]       misc_b_r;
	logic             debug_button_flag_r;
	logic             btn_prev_r;
	logic [24:0]      cyc_cnt_r;
	logic [24:0]      blink_cnt_r;
	logic             blink_phase_r;
	logic [2:0]       sys_lamp_r;
	logic [1:0]       opt_lamp_r;
	logic [1:0]       cu_lamp_r;
	logic             pwr_out_r;
	logic             irq_r;
	cycle_state_t     cyc_state_r;

	// bus decode
	wire  [7:0] idx     = avs_address[9:2];
	wire  [7:0] wd      = avs_writedata[7:0];
	wire        rd_take = clk_en && avs_read && wait_r;
	wire        wr_take = clk_en && avs_write && !wait_r && avs_byteenable[0];
	wire        wr_lamp = wr_take && (idx == IDX_LAMP);
	wire        wr_port = wr_take && (idx == IDX_PORT);
	wire        wr_rst  = wr_take && (idx == IDX_RST);
	wire        wr_fw   = wr_take && (idx == IDX_FWDIS);
	wire        wr_pwr  = wr_take && (idx == IDX_PWR);
	wire        wr_fl   = wr_take && (idx == IDX_FLASH);
	wire        wr_mask = wr_take && (idx == IDX_MASK);
	wire        wr_rail = wr_take && (idx == IDX_RAIL);
	wire        wr_isoa = wr_take && (idx == IDX_ISOA);
	wire        wr_isob = wr_take && (idx == IDX_ISOB);
	wire        wr_mica = wr_take && (idx == IDX_MISCA);
	wire        wr_micb = wr_take && (idx == IDX_MISCB);
	wire        wr_clr  = wr_take && (idx == IDX_CLR) && !wd[CLR_DBG_BIT];
	wire        cyc_go  = wr_pwr && !wd[CYC_BIT] && (cyc_state_r == CYC_IDLE);
	wire        cyc_end = (cyc_state_r == CYC_OFF) && (cyc_cnt_r == 25'h0000000);
	wire        btn_fall = btn_prev_r && !debug_button_n;

	// status views
	wire  [6:0] irq_view = {hot_swap_good, irq_src_n};
	wire  [6:0] irq_act  = {!hot_swap_good, ~irq_src_n};
	wire        irq_nxt  = |(irq_act & ~mask_r);

	// read selection, unmapped and unused bits read zero, except PWR bit 1, MISCB bit 2 and CLR bit 1, which read one
	wire  [7:0] rd_byte =
		(idx == IDX_BOARD) ? {4'h0, board_rev} :
		(idx == IDX_REV)   ? {1'b0, ID_RELEASED, ID_LOGIC_REV} :
		(idx == IDX_SUB)   ? ID_SUB_REV :
		(idx == IDX_LAMP)  ? {3'h0, lamp_ctl_r} :
		(idx == IDX_PORT)  ? {port_src_r, 3'h0, port_lamp_r} :
		(idx == IDX_OOB)   ? {5'h00, mgmt_lamp_input} :
		(idx == IDX_WDOG)  ? {7'h00, watchdog_state} :
		(idx == IDX_RST)   ? {2'h0, rst_ctl_r} :
		(idx == IDX_SLEEP) ? {4'h0, sleep_state} :
		(idx == IDX_FWDIS) ? {6'h00, fw_dis_r} :
		(idx == IDX_PWR)   ? {5'h00, pwr_cyc_n_r, 1'b1, pwr_en_r} :
		(idx == IDX_FLASH) ? {6'h00, flash_r} :
		(idx == IDX_IRQ)   ? {1'b0, irq_view} :
		(idx == IDX_MASK)  ? {1'b0, mask_r} :
		(idx == IDX_PGOOD) ? {3'h0, rail_good} :
		(idx == IDX_RAIL)  ? rail_r :
		(idx == IDX_ISOA)  ? iso_a_r :
		(idx == IDX_ISOB)  ? {2'h0, iso_b_r} :
		(idx == IDX_THERM) ? {7'h00, thermal_trip_n} :
		(idx == IDX_MISCA) ? {misc_a_r, 1'b0} :
		(idx == IDX_MISCB) ? {5'h00, 1'b1, misc_b_r} :
		(idx == IDX_LOAD)  ? {2'h0, misc_status_in, redriver_load_done_n} :
		(idx == IDX_UART)  ? {6'h00, console_route_a, console_route_b} :
		(idx == IDX_STATB) ? {bandwidth_full, misc4_in[6:3], 1'b0, misc4_in[1:0]} :
		(idx == IDX_STATC) ? {front_power_button_n, debug_button_flag_r, 6'h00} :
		(idx == IDX_CLR)   ? 8'h02 : 8'h00;

	// one wait cycle per access, then waitrequest drops for one cycle
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wait_r  <= 1'b1;
			rdata_r <= 32'h00000000;
		end else if (clk_en) begin
			wait_r <= !(wait_r && (avs_read || avs_write));
			if (rd_take)
				rdata_r <= {24'h000000, rd_byte};
		end
	end

	// software control registers; writes to read-only bits fall away
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			lamp_ctl_r  <= RST_LAMP;
			port_src_r  <= 1'b1;
			port_lamp_r <= 4'h0;
			rst_ctl_r   <= RST_RSTC;
			fw_dis_r    <= 2'h0;
			pwr_en_r    <= 1'b0;
			flash_r     <= 2'h0;
			mask_r      <= RST_MASK;
			rail_r      <= RST_RAIL;
			iso_a_r     <= 8'h00;
			iso_b_r     <= RST_ISOB;
			misc_a_r    <= RST_MISCA;
			misc_b_r    <= 2'h0;
		end else begin
			if (wr_lamp) lamp_ctl_r <= wd[4:0];
			if (wr_port) begin
				port_src_r  <= wd[7];
				port_lamp_r <= wd[3:0];
			end
			if (wr_rst) rst_ctl_r <= wd[5:0];
			if (wr_fw) fw_dis_r <= wd[1:0];
			if (wr_pwr) pwr_en_r <= wd[0];
			if (wr_fl) flash_r <= wd[1:0];
			if (wr_mask) mask_r <= wd[6:0];
			if (wr_rail) rail_r <= wd & MSK_RAIL;
			if (wr_isoa) iso_a_r <= wd & MSK_ISOA;
			if (wr_isob) iso_b_r <= wd[5:0] & MSK_ISOB;
			if (wr_mica) misc_a_r <= wd[7:1];
			if (wr_micb) misc_b_r <= wd[1:0];
		end
	end

	// power cycle sequencer; the bit is owned by hardware while cycling
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cyc_state_r <= CYC_IDLE;
			cyc_cnt_r   <= 25'h0000000;
			pwr_cyc_n_r <= 1'b1;
		end else if (clk_en) begin
			case (cyc_state_r)
				CYC_IDLE: begin
					if (cyc_go) begin
						cyc_state_r <= CYC_OFF;
						cyc_cnt_r   <= 25'(CYCLE_CYC - 1);
						pwr_cyc_n_r <= 1'b0;
					end
				end
				CYC_OFF: begin
					if (cyc_end) begin
						cyc_state_r <= CYC_IDLE;
						pwr_cyc_n_r <= 1'b1;
					end else
						cyc_cnt_r <= cyc_cnt_r - 25'h0000001;
				end
				default: cyc_state_r <= CYC_IDLE;
			endcase
		end
	end

	// debug button edge latch; a new edge beats a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			btn_prev_r          <= 1'b1;
			debug_button_flag_r <= 1'b1;
		end else if (clk_en) begin
			btn_prev_r <= debug_button_n;
			if (btn_fall)
				debug_button_flag_r <= 1'b0;
			else if (wr_clr)
				debug_button_flag_r <= 1'b1;
		end
	end

	// blink timebase, free running so all three system lamp colours blink in step
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			blink_cnt_r   <= 25'h0000000;
			blink_phase_r <= 1'b1;
		end else if (clk_en) begin
			if (blink_cnt_r == 25'h0000000) begin
				blink_cnt_r   <= 25'(BLINK_CYC - 1);
				blink_phase_r <= !blink_phase_r;
			end else
				blink_cnt_r <= blink_cnt_r - 25'h0000001;
		end
	end

	// lamp and output selection
	wire        sw_lit   = !lamp_ctl_r[LAMP_BLK_BIT] || blink_phase_r;
	wire  [2:0] sys_nxt  = lamp_ctl_r[LAMP_HW_BIT] ? hw_lamp_n : (sw_lit ? lamp_ctl_r[2:0] : 3'h7);
	wire  [1:0] cu_nxt   = port_src_r ? ~mgmt_lamp_input[1:0] : port_lamp_r[1:0];

	// output stage registers so pins never glitch on decode
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sys_lamp_r <= 3'h7;
			opt_lamp_r <= 2'h0;
			cu_lamp_r  <= 2'h0;
			pwr_out_r  <= 1'b0;
			irq_r      <= 1'b0;
		end else if (clk_en) begin
			sys_lamp_r <= sys_nxt;
			opt_lamp_r <= port_lamp_r[3:2];
			cu_lamp_r  <= cu_nxt;
			pwr_out_r  <= pwr_en_r && (cyc_state_r == CYC_IDLE);
			irq_r      <= irq_nxt;
		end
	end

	// port wiring, all from flops
	assign avs_readdata            = rdata_r;
	assign avs_waitrequest         = wait_r;
	assign lamp_red_n              = sys_lamp_r[0];
	assign lamp_green_n            = sys_lamp_r[1];
	assign lamp_blue_n             = sys_lamp_r[2];
	assign optical_lamp_orange     = opt_lamp_r[0];
	assign optical_lamp_green      = opt_lamp_r[1];
	assign copper_lamp_green       = cu_lamp_r[0];
	assign copper_lamp_orange      = cu_lamp_r[1];
	assign module_reset_n          = rst_ctl_r[0];
	assign phy_reset_n             = rst_ctl_r[1];
	assign bus_switch_reset_n      = rst_ctl_r[2];
	assign slot_reset_n            = rst_ctl_r[3];
	assign module_power_good_drive = rst_ctl_r[4];
	assign module_power_button     = rst_ctl_r[5];
	assign module_power_en         = pwr_out_r;
	assign firmware_disable_n      = fw_dis_r;
	assign flash_to_mgmt           = flash_r[0];
	assign flash_oe_n              = flash_r[1];
	assign rail_enable             = rail_r;
	assign isolation_a_n           = iso_a_r;
	assign isolation_b_n           = iso_b_r;
	assign misc_control            = misc_a_r;
	assign misc_control_b          = misc_b_r;
	assign irq_out                 = irq_r;

	// checks
	sequence s_cyc_write;
		cyc_go && clk_en;
	endsequence
	sequence s_power_down;
		!module_power_en && !pwr_cyc_n_r;
	endsequence

	a_rev_readback: assert property (@(posedge core_clk) disable iff (sys_rst)
		rd_take && idx == IDX_REV |=> avs_readdata[7:0] == {1'b0, ID_RELEASED, ID_LOGIC_REV})
		else $error("revision readback wrong");
	a_sw_red_lamp: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && !lamp_ctl_r[LAMP_HW_BIT] && !lamp_ctl_r[LAMP_BLK_BIT] |=> lamp_red_n == $past(lamp_ctl_r[0]))
		else $error("software red lamp mismatch");
	a_blink_dark: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && !lamp_ctl_r[LAMP_HW_BIT] && lamp_ctl_r[LAMP_BLK_BIT] && !blink_phase_r
		|=> lamp_red_n && lamp_green_n && lamp_blue_n)
		else $error("blink dark phase lamp lit");
	a_copper_follow: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && port_src_r |=> copper_lamp_green == !$past(mgmt_lamp_input[0]))
		else $error("copper lamp not following input");
	a_reset_drive: assert property (@(posedge core_clk) disable iff (sys_rst)
		wr_rst && !wd[3] |=> !slot_reset_n)
		else $error("slot reset not asserted");
	a_cycle_power: assert property (@(posedge core_clk) disable iff (sys_rst)
		s_cyc_write ##1 clk_en |=> s_power_down)
		else $error("power cycle did not remove power");
	a_cycle_return: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && cyc_end |=> pwr_cyc_n_r && cyc_state_r == CYC_IDLE)
		else $error("power cycle bit did not return");
	a_irq_unmasked: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && !irq_src_n[0] && !mask_r[0] |=> irq_out)
		else $error("unmasked source gave no interrupt");
	a_button_latch: assert property (@(posedge core_clk) disable iff (sys_rst)
		clk_en && btn_fall |=> !debug_button_flag_r [*1])
		else $error("button edge not latched");
	a_flag_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
		wr_clr && !btn_fall |=> debug_button_flag_r)
		else $error("flag not cleared");
	a_freeze_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
		!clk_en |=> $stable(irq_out) && $stable(lamp_red_n))
		else $error("outputs moved with clock enable low");
	a_flash_owner: assert property (@(posedge core_clk) disable iff (sys_rst)
		wr_fl |=> flash_to_mgmt == $past(wd[0]) && flash_oe_n == $past(wd[1]))
		else $error("flash select not written");
	a_iso_reserved: assert property (@(posedge core_clk) disable iff (sys_rst)
		wr_isob |=> !isolation_b_n[1] && isolation_b_n[0] == $past(wd[0]))
		else $error("second isolation write wrong");
endmodule // module_ctrl_reg_bank

// ---- tb/mgmt_host_model.sv ----
module mgmt_host_model (
	// clock
	input  wire logic        core_clk,
	// avalon-mm master side
	output logic      [9:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [31:0] avs_writedata,
	output logic      [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	// read result handed to the bench
	output logic             rd_valid,
	output logic      [31:0] rd_data
);
	timeunit 1ns;
	timeprecision 1ns;

	// bus idle from time zero
	initial begin
		avs_address    = 10'h000;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'h00000000;
		avs_byteenable = 4'h0;
		rd_valid       = 1'b0;
		rd_data        = 32'h00000000;
	end

	// one access; request held until waitrequest is seen low, however long it takes
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
		@(posedge core_clk);
		avs_address    <= {idx, 2'b00};
		avs_read       <= ~wr;
		avs_write      <= wr;
		avs_writedata  <= {24'h000000, d};
		avs_byteenable <= be;
		do
			@(posedge core_clk);
		while (avs_waitrequest !== 1'b0);
		rd_data  <= avs_readdata;
		rd_valid <= ~wr;
		// released lines change, so a slave that keeps sampling them is caught
		avs_read      <= 1'b0;
		avs_write     <= 1'b0;
		avs_address   <= ~avs_address;
		avs_writedata <= ~avs_writedata;
		@(posedge core_clk);
		rd_valid <= 1'b0;
	endtask
endmodule // mgmt_host_model

// ---- tb/module_ctrl_reg_bank_tb.sv ----
`define CHECK_EQ(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
	$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module module_ctrl_reg_bank_tb
	import ctrl_regs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BLK = 4;
	localparam int CYC = 8;

	logic core_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
	logic [3:0] board_rev = 4'h0, sleep_state = 4'h0;
	logic [2:0] hw_lamp_n = 3'h7, mgmt_lamp_input = 3'h7, redriver_load_done_n = 3'h7;
	logic [2:0] misc_status_in = 3'h0;
	logic [5:0] irq_src_n = 6'h3F;
	logic [4:0] rail_good = 5'h1F;
	logic [6:0] misc4_in = 7'h00;
	logic watchdog_state = 1'b0, hot_swap_good = 1'b1, thermal_trip_n = 1'b1, console_route_a = 1'b0;
	logic console_route_b = 1'b0, bandwidth_full = 1'b1, front_power_button_n = 1'b1, debug_button_n = 1'b1;
	logic [9:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd_data;
	logic [3:0] avs_byteenable;
	logic avs_read, avs_write, avs_waitrequest, rd_valid;
	logic lamp_red_n, lamp_green_n, lamp_blue_n, optical_lamp_green, optical_lamp_orange;
	logic copper_lamp_green, copper_lamp_orange, module_power_button, module_power_good_drive;
	logic slot_reset_n, bus_switch_reset_n, phy_reset_n, module_reset_n, module_power_en;
	logic flash_to_mgmt, flash_oe_n, irq_out;
	logic [1:0] firmware_disable_n, misc_control_b;
	logic [7:0] rail_enable, isolation_a_n;
	logic [5:0] isolation_b_n;
	logic [7:1] misc_control;
	logic [15:0] exp_q[$];
	logic [15:0] ent;
	logic [31:0] s = 32'h4df8;
	logic [31:0] a;
	int n_fail = 0, n_tests = 0, n;

	always #25 core_clk = ~core_clk;

	module_ctrl_reg_bank #(.BLINK_CYC(BLK), .CYCLE_CYC(CYC)) i_module_ctrl_reg_bank (.*);

	mgmt_host_model i_mgmt_host_model (.core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rd_valid(rd_valid), .rd_data(rd_data));

	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		v = v ^ (v << 5);
		return v;
	endfunction

	// read: note the expectation, then run the access; the monitor compares
	task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [7:0] m);
		exp_q.push_back({m, e});
		i_mgmt_host_model.xfer(1'b0, idx, 8'h00, 4'hF);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		i_mgmt_host_model.xfer(1'b1, idx, d, 4'hF);
	endtask
	// let output-stage flops settle, sample mid-cycle
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	task automatic count_red_off(output int c);
		c = 0;
		repeat (4 * BLK) begin
			@(negedge core_clk);
			c += (lamp_red_n !== 1'b0);
		end
	endtask

	// oldest note against each returned read word; upper bits must be zero
	always @(posedge core_clk) begin
		if (rd_valid === 1'b1) begin
			ent = exp_q.pop_front();
			`CHECK_EQ(rd_data & {24'hFFFFFF, ent[15:8]}, {24'h000000, ent[7:0]})
		end
	end

	task automatic summarize();
		$display("tests %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// hang guard, far beyond the expected run
	initial begin
		repeat (6000) @(posedge core_clk);
		n_fail++;
		$display("timeout waiting for the bus");
		summarize();
	end

	initial begin
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		tick(2);
		`CHECK_EQ({lamp_blue_n, lamp_green_n, lamp_red_n, optical_lamp_green, optical_lamp_orange, copper_lamp_green, copper_lamp_orange}, 7'h70)
		`CHECK_EQ({module_power_button, module_power_good_drive, slot_reset_n, bus_switch_reset_n, phy_reset_n, module_reset_n, module_power_en}, 7'h7E)
		`CHECK_EQ({rail_enable, isolation_a_n, isolation_b_n, misc_control, irq_out, flash_to_mgmt, flash_oe_n}, {8'hDF, 8'h00, 6'h3C, 7'h07, 3'b000})
		`CHECK_EQ({firmware_disable_n, misc_control_b}, 4'h0)
		// reset values through the bus
		rd(8'h01, {1'b0, ID_RELEASED, ID_LOGIC_REV}, 8'hFF);
		rd(8'h02, ID_SUB_REV, 8'hFF);
		rd(8'h08, {3'b000, RST_LAMP}, 8'hFF);
		rd(8'h09, 8'h80, 8'hFF);
		rd(8'h10, 8'h3F, 8'hFF);
		rd(8'h14, 8'h06, 8'hFF);
		rd(8'h15, 8'h00, 8'hFF);
		rd(8'h28, 8'h22, 8'hFF);
		rd(8'h31, 8'hDF, 8'hFF);
		rd(8'h32, 8'h00, 8'hFF);
		rd(8'h33, 8'h3C, 8'hFF);
		rd(8'h35, 8'h0E, 8'hFF);
		rd(8'h36, 8'h04, 8'hFF);
		rd(8'h3A, 8'hC0, 8'hC0);
		rd(8'h3F, 8'h00, 8'hFF);
		// random status inputs and a random isolation pattern
		for (int i = 0; i < 4; i++) begin
			s = xs(s);
			a = s;
			s = xs(s);
			@(posedge core_clk);
			{board_rev, mgmt_lamp_input, watchdog_state, sleep_state, irq_src_n, hot_swap_good, rail_good,
				thermal_trip_n, misc_status_in, redriver_load_done_n} <= a[30:0];
			{console_route_a, console_route_b, bandwidth_full, misc4_in, front_power_button_n} <= s[10:0];
			tick(3);
			rd(8'h00, {4'h0, board_rev}, 8'hFF);
			rd(8'h0A, {5'h00, mgmt_lamp_input}, 8'hFF);
			rd(8'h0C, {7'h00, watchdog_state}, 8'hFF);
			rd(8'h11, {4'h0, sleep_state}, 8'hFF);
			rd(8'h21, {1'b0, hot_swap_good, irq_src_n}, 8'hFF);
			rd(8'h30, {3'b000, rail_good}, 8'hFF);
			rd(8'h34, {7'h00, thermal_trip_n}, 8'hFF);
			rd(8'h37, {2'b00, misc_status_in, redriver_load_done_n}, 8'hFF);
			rd(8'h38, {6'h00, console_route_a, console_route_b}, 8'hFF);
			rd(8'h39, {bandwidth_full, misc4_in[6:3], 1'b0, misc4_in[1:0]}, 8'hFF);
			rd(8'h3A, {front_power_button_n, 7'h00}, 8'h80);
			wr(8'h32, s[23:16]);
			rd(8'h32, s[23:16] & 8'hDF, 8'hFF);
			`CHECK_EQ(isolation_a_n, s[23:16] & 8'hDF)
		end
		// system lamp: steady, blinking, software colours, hardware mode
		wr(8'h08, 8'h00);
		count_red_off(n);
		`CHECK_EQ(n == 0, 1'b1)
		wr(8'h08, 8'h08);
		count_red_off(n);
		`CHECK_EQ(n > 0 && n < 4 * BLK, 1'b1)
		wr(8'h08, 8'h05);
		tick(2);
		`CHECK_EQ({lamp_blue_n, lamp_green_n, lamp_red_n}, 3'b101)
		@(posedge core_clk);
		hw_lamp_n <= 3'b011;
		wr(8'h08, 8'h10);
		tick(2);
		`CHECK_EQ({lamp_blue_n, lamp_green_n, lamp_red_n}, 3'b011)
		// port lamps by software, then copper lamps from the management inputs
		wr(8'h09, 8'h0E);
		tick(2);
		`CHECK_EQ({optical_lamp_green, optical_lamp_orange, copper_lamp_orange, copper_lamp_green}, 4'hE)
		@(posedge core_clk);
		mgmt_lamp_input <= 3'b110;
		wr(8'h09, 8'h80);
		tick(2);
		`CHECK_EQ({copper_lamp_orange, copper_lamp_green}, 2'b01)
		// reset lines, each bit to its own output
		wr(8'h10, 8'h2A);
		tick(1);
		`CHECK_EQ({module_power_button, module_power_good_drive, slot_reset_n, bus_switch_reset_n, phy_reset_n, module_reset_n}, 6'h2A)
		wr(8'h10, 8'h3F);
		// power on, then a full power cycle that ends by itself
		wr(8'h14, 8'h05);
		tick(2);
		`CHECK_EQ(module_power_en, 1'b1)
		wr(8'h14, 8'h01);
		rd(8'h14, 8'h03, 8'hFF);
		`CHECK_EQ(module_power_en, 1'b0)
		tick(CYC + 4);
		rd(8'h14, 8'h07, 8'hFF);
		tick(2);
		`CHECK_EQ(module_power_en, 1'b1)
		// flash owner, a write with no byte enabled, a read-only target
		wr(8'h15, 8'hFF);
		rd(8'h15, 8'h03, 8'hFF);
		`CHECK_EQ({flash_oe_n, flash_to_mgmt}, 2'b11)
		i_mgmt_host_model.xfer(1'b1, 8'h15, 8'h00, 4'h0);
		rd(8'h15, 8'h03, 8'hFF);
		wr(8'h01, 8'hFF);
		rd(8'h01, {1'b0, ID_RELEASED, ID_LOGIC_REV}, 8'hFF);
		// rails, second isolation, misc enables
		wr(8'h31, 8'h00);
		tick(1);
		`CHECK_EQ(rail_enable, 8'h00)
		wr(8'h31, 8'hFF);
		rd(8'h31, 8'hDF, 8'hFF);
		wr(8'h33, 8'hFF);
		rd(8'h33, 8'h3D, 8'hFF);
		`CHECK_EQ(isolation_b_n, 6'h3D)
		wr(8'h35, 8'h70);
		rd(8'h35, 8'h70, 8'hFF);
		`CHECK_EQ(misc_control, 7'h38)
		// firmware disable and second misc register, then the clear register
		wr(8'h12, 8'h03);
		rd(8'h12, 8'h03, 8'hFF);
		wr(8'h36, 8'hFF);
		rd(8'h36, 8'h07, 8'hFF);
		`CHECK_EQ({firmware_disable_n, misc_control_b}, 4'hF)
		rd(8'h3B, 8'h02, 8'hFF);
		// interrupt output against mask
		@(posedge core_clk);
		irq_src_n <= 6'h3E;
		hot_swap_good <= 1'b1;
		wr(8'h28, 8'h00);
		tick(3);
		`CHECK_EQ(irq_out, 1'b1)
		wr(8'h28, 8'h01);
		tick(3);
		`CHECK_EQ(irq_out, 1'b0)
		@(posedge core_clk);
		hot_swap_good <= 1'b0;
		tick(3);
		`CHECK_EQ(irq_out, 1'b1)
		// clock enable low freezes the interrupt output
		@(posedge core_clk);
		clk_en        <= 1'b0;
		hot_swap_good <= 1'b1;
		tick(3);
		`CHECK_EQ(irq_out, 1'b1)
		@(posedge core_clk);
		clk_en        <= 1'b1;
		hot_swap_good <= 1'b0;
		wr(8'h28, 8'hFF);
		rd(8'h28, 8'h7F, 8'hFF);
		`CHECK_EQ(irq_out, 1'b0)
		// debug button edge latches, software clears
		@(posedge core_clk);
		debug_button_n <= 1'b0;
		tick(3);
		rd(8'h3A, 8'h00, 8'h40);
		wr(8'h3B, 8'h00);
		rd(8'h3A, 8'h40, 8'h40);
		tick(2);
		`CHECK_EQ(exp_q.size(), 0)
		summarize();
	end
endmodule // module_ctrl_reg_bank_tb
